// File: hdl/sgs_selector.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Group one ranks highest, group eight lowest, among simultaneous requests.
// - Each request input may be a short pulse or a held level.
// - Held group one request makes every other request ignored.
// - A held request blocks lower-priority group requests and remote selection of its own group.
// - Held group eight request blocks only remote selection of group eight.
// - Enabled and disabled events when groups two to eight enter or leave use.
// - On/off events for requests, remote, local, force and active groups.
// - Failure events: unconfigured group, failed force, lower-priority rejection.
// - Every event carries the time stamp of its occurrence.
// - Pulse-selected group stays active until another group is requested.
// - Forcing ignores inputs and takes commanded group until forcing ends.
// - Remote change refused while a higher group is held by input.
module sgs_selector
	import sgs_pkg::*;
(
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// Group request inputs
	input  wire logic             group_one_request,
	input  wire logic             group_two_request,
	input  wire logic             group_three_request,
	input  wire logic             group_four_request,
	input  wire logic             group_five_request,
	input  wire logic             group_six_request,
	input  wire logic             group_seven_request,
	input  wire logic             group_eight_request,
	// Register port
	input  wire logic [AW-1:0]    reg_addr,
	input  wire logic [DW-1:0]    reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic [DW-1:0]         reg_rdata_q,
	// Active group
	output logic [GRP_N-1:0]      active_onehot_q,
	// Events
	output logic [EV_N-1:0]       ev_on_q,
	output logic [EV_N-1:0]       ev_off_q,
	output logic                  ev_valid_q,
	output logic [TSW-1:0]        ev_stamp_q,
	// Interrupt
	output logic                  irq_q
);

	// ****************************************
	// Declarations
	// ****************************************
	sgs_grp_t          req_raw;
	sgs_grp_t          used_mask;
	sgs_grp_t          req_m;
	sgs_grp_t          req_prev_q;
	sgs_grp_t          req_rise;
	sgs_grp_t          higher_held;
	logic              win_valid;
	logic [GIW-1:0]    win_idx;

	logic              force_q;
	logic [GFW-1:0]    fgrp_q;
	logic [GFW-1:0]    used_q;
	logic [GIW-1:0]    act_q;
	logic [GIW-1:0]    act_d;
	logic              remote_q;
	logic              local_q;
	logic              fail_ncfg_q;
	logic              fail_force_q;
	logic              fail_prio_q;
	logic [IRQ_W-1:0]  irq_stat_q;
	logic [IRQ_W-1:0]  irq_mask_q;
	logic [TSW-1:0]    ts_q;
	logic [8:0]        tick_cnt_q;

	logic              wr_ctrl;
	logic              wr_remote;
	logic              wr_local;
	logic [GFW-1:0]    wnum;
	logic              force_cmd;
	logic [GFW-1:0]    force_num;
	logic              fail_ncfg;
	logic              fail_force;
	logic              fail_prio;
	logic              accept;
	logic [EV_N-1:0]   ev_lvl;
	logic [IRQ_W-1:0]  irq_set;

	assign req_raw = {group_eight_request, group_seven_request, group_six_request, group_five_request,
		group_four_request, group_three_request, group_two_request, group_one_request};

	// ****************************************
	// Request conditioning
	// ****************************************
	always_comb begin
		for (int g = 0; g < GRP_N; g++) begin
			used_mask[g] = sgs_grp_used(g[GIW-1:0], used_q);
		end
	end

	// Level and pulse look alike: a pulse is a held level of short life
	assign req_m = req_raw & used_mask;
	assign req_rise = req_m & ~req_prev_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			req_prev_q <= '0;
		end else begin
			req_prev_q <= req_m;
		end
	end

	sgs_prio_pick u_pick (
		.rise        (req_rise),
		.held        (req_m),
		.win_valid   (win_valid),
		.win_idx     (win_idx),
		.higher_held (higher_held)
	);

	// ****************************************
	// Register writes
	// ****************************************
	assign wnum = reg_wdata[GFW-1:0];
	assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
	assign wr_remote = reg_wr && (reg_addr == REG_REMOTE) && (wnum != GRP_NONE);
	assign wr_local = reg_wr && (reg_addr == REG_LOCAL) && (wnum != GRP_NONE);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			force_q <= 1'b0;
			fgrp_q <= GRP_NONE;
		end else if (wr_ctrl) begin
			force_q <= reg_wdata[CTRL_FORCE_BIT];
			fgrp_q <= reg_wdata[CTRL_FGRP_LSB +: GFW];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			used_q <= USED_RST;
		end else if (reg_wr && (reg_addr == REG_USED)) begin
			// Zero or out of range falls back to the nearest legal count
			if (wnum == GRP_NONE) begin
				used_q <= USED_RST;
			end else if (wnum > GRP_N[GFW-1:0]) begin
				used_q <= GRP_N[GFW-1:0];
			end else begin
				used_q <= wnum;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_mask_q <= '0;
		end else if (reg_wr && (reg_addr == REG_IRQ_MASK)) begin
			irq_mask_q <= reg_wdata[IRQ_W-1:0];
		end
	end

	// ****************************************
	// Group selection
	// ****************************************
	// Force group takes effect when forcing turns on or is rewritten
	assign force_num = reg_wdata[CTRL_FGRP_LSB +: GFW];
	assign force_cmd = wr_ctrl && reg_wdata[CTRL_FORCE_BIT] && (force_num != GRP_NONE);

	always_comb begin
		act_d = act_q;
		fail_ncfg = 1'b0;
		fail_force = 1'b0;
		fail_prio = 1'b0;
		accept = 1'b0;
		if (force_q || force_cmd) begin
			// Inputs are not looked at while forcing
			if (force_cmd) begin
				if (sgs_num_ok(force_num, used_q)) begin
					act_d = sgs_num_idx(force_num);
					accept = 1'b1;
				end else begin
					fail_ncfg = 1'b1;
				end
			end else if (wr_local || wr_remote) begin
				if (sgs_num_ok(wnum, used_q)) begin
					act_d = sgs_num_idx(wnum);
					accept = 1'b1;
				end else begin
					fail_ncfg = 1'b1;
				end
			end
		end else begin
			if (|(req_rise & higher_held)) begin
				fail_prio = 1'b1;
			end
			if (|(req_raw & ~used_mask & ~req_prev_q)) begin
				fail_ncfg = 1'b1;
			end
			if (wr_local) begin
				fail_force = 1'b1;
			end
			if (win_valid) begin
				act_d = win_idx;
				accept = 1'b1;
			end else if (wr_remote) begin
				if (!sgs_num_ok(wnum, used_q)) begin
					fail_ncfg = 1'b1;
				end else if (higher_held[sgs_num_idx(wnum)] || req_m[sgs_num_idx(wnum)]) begin
					fail_prio = 1'b1;
				end else begin
					act_d = sgs_num_idx(wnum);
					accept = 1'b1;
				end
			end
		end
		// Shrinking the used set must not leave a dead group active
		if (!sgs_grp_used(act_d, used_q)) begin
			act_d = ACT_RST;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			act_q <= ACT_RST;
		end else begin
			act_q <= act_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			active_onehot_q <= sgs_grp_t'(1);
		end else begin
			active_onehot_q <= sgs_grp_t'(1) << act_d;
		end
	end

	// ****************************************
	// Request and failure levels
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			remote_q <= 1'b0;
			local_q <= 1'b0;
		end else begin
			remote_q <= wr_remote;
			local_q <= wr_local;
		end
	end

	// Failure level stays up until a later accepted change; a new fail wins
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fail_ncfg_q <= 1'b0;
			fail_force_q <= 1'b0;
			fail_prio_q <= 1'b0;
		end else begin
			fail_ncfg_q <= fail_ncfg | (fail_ncfg_q & ~accept);
			fail_force_q <= fail_force | (fail_force_q & ~accept);
			fail_prio_q <= fail_prio | (fail_prio_q & ~accept);
		end
	end

	// ****************************************
	// Time stamp, microsecond resolution
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tick_cnt_q <= '0;
			ts_q <= '0;
		end else if (tick_cnt_q == 9'(TS_TICK_CYC - 1)) begin
			tick_cnt_q <= '0;
			ts_q <= ts_q + 32'h1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 9'h1;
		end
	end

	// ****************************************
	// Events
	// ****************************************
	always_comb begin
		ev_lvl = '0;
		ev_lvl[EV_USED_LSB +: GRP_N-1] = used_mask[GRP_N-1:1];
		ev_lvl[EV_REQ_LSB +: GRP_N] = req_raw;
		ev_lvl[EV_REMOTE] = remote_q;
		ev_lvl[EV_LOCAL] = local_q;
		ev_lvl[EV_FORCE] = force_q;
		ev_lvl[EV_FAIL_NCFG] = fail_ncfg_q;
		ev_lvl[EV_FAIL_FORCE] = fail_force_q;
		ev_lvl[EV_FAIL_PRIO] = fail_prio_q;
		ev_lvl[EV_ACT_LSB +: GRP_N] = active_onehot_q;
	end

	sgs_event_edges u_events (
		.core_clk   (core_clk),
		.rst        (rst),
		.lvl        (ev_lvl),
		.ts         (ts_q),
		.ev_on_q    (ev_on_q),
		.ev_off_q   (ev_off_q),
		.ev_valid_q (ev_valid_q),
		.ev_stamp_q (ev_stamp_q)
	);

	// ****************************************
	// Interrupt
	// ****************************************
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_ACT] = (act_d != act_q);
		irq_set[IRQ_NCFG] = fail_ncfg;
		irq_set[IRQ_FORCE] = fail_force;
		irq_set[IRQ_PRIO] = fail_prio;
	end

	// Set beats a same-cycle write-one clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_stat_q <= '0;
		end else if (reg_wr && (reg_addr == REG_IRQ_STAT)) begin
			irq_stat_q <= (irq_stat_q & ~reg_wdata[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ****************************************
	// Register read, data one cycle later
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata_q <= '0;
		end else if (reg_rd) begin
			reg_rdata_q <= '0;
			unique case (reg_addr)
				REG_CTRL: begin
					reg_rdata_q[CTRL_FORCE_BIT] <= force_q;
					reg_rdata_q[CTRL_FGRP_LSB +: GFW] <= fgrp_q;
				end
				REG_USED: begin
					reg_rdata_q[GFW-1:0] <= used_q;
				end
				REG_STATUS: begin
					reg_rdata_q[STAT_ACT_LSB +: GFW] <= {1'b0, act_q} + 4'h1;
					reg_rdata_q[STAT_FORCE_BIT] <= force_q;
					reg_rdata_q[STAT_USED_LSB +: GRP_N] <= used_mask;
					reg_rdata_q[STAT_REQ_LSB +: GRP_N] <= req_raw;
					reg_rdata_q[STAT_FAIL_LSB +: 3] <= {fail_prio_q, fail_force_q, fail_ncfg_q};
				end
				REG_IRQ_STAT: begin
					reg_rdata_q[IRQ_W-1:0] <= irq_stat_q;
				end
				REG_IRQ_MASK: begin
					reg_rdata_q[IRQ_W-1:0] <= irq_mask_q;
				end
				REG_TSTAMP: begin
					reg_rdata_q <= ts_q;
				end
				default: begin
					reg_rdata_q <= '0;
				end
			endcase
		end else begin
			reg_rdata_q <= '0;
		end
	end

endmodule
`default_nettype wire

// File: hdl/sgs_pkg.sv
`default_nettype none
package sgs_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int GRP_N = 8;
	localparam int GIW   = 3;
	localparam int GFW   = 4;
	localparam int DW    = 32;
	localparam int AW    = 8;
	localparam int TSW   = 32;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [AW-1:0] REG_CTRL     = 8'h00;
	localparam logic [AW-1:0] REG_USED     = 8'h04;
	localparam logic [AW-1:0] REG_REMOTE   = 8'h08;
	localparam logic [AW-1:0] REG_LOCAL    = 8'h0c;
	localparam logic [AW-1:0] REG_STATUS   = 8'h10;
	localparam logic [AW-1:0] REG_IRQ_STAT = 8'h14;
	localparam logic [AW-1:0] REG_IRQ_MASK = 8'h18;
	localparam logic [AW-1:0] REG_TSTAMP   = 8'h1c;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_FORCE_BIT = 0;
	localparam int CTRL_FGRP_LSB  = 4;
	localparam int STAT_ACT_LSB   = 0;
	localparam int STAT_FORCE_BIT = 4;
	localparam int STAT_USED_LSB  = 8;
	localparam int STAT_REQ_LSB   = 16;
	localparam int STAT_FAIL_LSB  = 24;

	// ****************************************
	// Event vector layout
	// ****************************************
	localparam int EV_USED_LSB   = 0;
	localparam int EV_REQ_LSB    = 7;
	localparam int EV_REMOTE     = 15;
	localparam int EV_LOCAL      = 16;
	localparam int EV_FORCE      = 17;
	localparam int EV_FAIL_NCFG  = 18;
	localparam int EV_FAIL_FORCE = 19;
	localparam int EV_FAIL_PRIO  = 20;
	localparam int EV_ACT_LSB    = 21;
	localparam int EV_N          = 29;

	// ****************************************
	// Interrupt status bits
	// ****************************************
	localparam int IRQ_ACT   = 0;
	localparam int IRQ_NCFG  = 1;
	localparam int IRQ_FORCE = 2;
	localparam int IRQ_PRIO  = 3;
	localparam int IRQ_W     = 4;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [GFW-1:0] USED_RST  = 4'h1;
	localparam logic [GIW-1:0] ACT_RST   = 3'h0;
	localparam logic [GFW-1:0] GRP_NONE  = 4'h0;
	localparam int             CLK_NS    = 4;
	localparam int             TS_TICK_NS  = 1000;
	localparam int             TS_TICK_CYC = (TS_TICK_NS + CLK_NS - 1) / CLK_NS;

	typedef logic [GRP_N-1:0] sgs_grp_t;

	// Group index (0 = group one) lies inside the used count
	function automatic logic sgs_grp_used(input logic [GIW-1:0] idx, input logic [GFW-1:0] cnt);
		sgs_grp_used = ({1'b0, idx} < cnt);
	endfunction

	// Group number field (1..8, 0 = none) names a used group
	function automatic logic sgs_num_ok(input logic [GFW-1:0] num, input logic [GFW-1:0] cnt);
		sgs_num_ok = (num != GRP_NONE) && (num <= cnt);
	endfunction

	function automatic logic [GIW-1:0] sgs_num_idx(input logic [GFW-1:0] num);
		logic [GFW-1:0] m;
		m = num - 4'h1;
		sgs_num_idx = m[GIW-1:0];
	endfunction

endpackage
`default_nettype wire

// File: hdl/sgs_prio_pick.sv
`timescale 1ns/10ps
`default_nettype none
module sgs_prio_pick
	import sgs_pkg::*;
(
	// Requests
	input  wire logic [GRP_N-1:0] rise,
	input  wire logic [GRP_N-1:0] held,
	// Result
	output logic                  win_valid,
	output logic [GIW-1:0]        win_idx,
	output logic [GRP_N-1:0]      higher_held
);

	// ****************************************
	// Fixed priority, index 0 highest
	// ****************************************
	always_comb begin
		logic acc;
		acc = 1'b0;
		win_valid = 1'b0;
		win_idx = ACT_RST;
		higher_held = '0;
		for (int g = 0; g < GRP_N; g++) begin
			higher_held[g] = acc;
			if (rise[g] && !acc && !win_valid) begin
				win_valid = 1'b1;
				win_idx = g[GIW-1:0];
			end
			acc = acc | held[g];
		end
	end

endmodule
`default_nettype wire

// File: hdl/sgs_event_edges.sv
`timescale 1ns/10ps
`default_nettype none
module sgs_event_edges
	import sgs_pkg::*;
(
	// Clock and reset
	input  wire logic            core_clk,
	input  wire logic            rst,
	// Levels and time
	input  wire logic [EV_N-1:0] lvl,
	input  wire logic [TSW-1:0]  ts,
	// Events
	output logic [EV_N-1:0]      ev_on_q,
	output logic [EV_N-1:0]      ev_off_q,
	output logic                 ev_valid_q,
	output logic [TSW-1:0]       ev_stamp_q
);

	logic [EV_N-1:0] prev_q;

	// ****************************************
	// Edge to one-cycle event pulses
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			prev_q <= '0;
			ev_on_q <= '0;
			ev_off_q <= '0;
			ev_valid_q <= 1'b0;
			ev_stamp_q <= '0;
		end else begin
			prev_q <= lvl;
			ev_on_q <= lvl & ~prev_q;
			ev_off_q <= ~lvl & prev_q;
			ev_valid_q <= |(lvl ^ prev_q);
			ev_stamp_q <= ts;
		end
	end

endmodule
`default_nettype wire

// File: verif/sgs_req_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Request lines: pulse or held level per group
// ****
module sgs_req_model
	import sgs_pkg::*;
(
	// Clock and reset
	input  wire logic     core_clk,
	input  wire logic     rst,
	// Commands from the bench
	input  wire sgs_grp_t hold,
	input  wire sgs_grp_t pulse,
	// Request lines
	output var sgs_grp_t  req_q
);
	// Registered, so lines move just after an edge and never race it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			req_q <= '0;
		end else begin
			req_q <= hold | pulse;
		end
	end
endmodule
`default_nettype wire

// File: verif/sgs_selector_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checker
// ****
module sgs_selector_asserts
	import sgs_pkg::*;
(
	// Clock and reset
	input wire logic             core_clk,
	input wire logic             rst,
	// Requests and writes
	input wire logic             group_one_request,
	input wire logic             group_two_request,
	input wire logic             group_three_request,
	input wire logic             group_four_request,
	input wire logic             group_five_request,
	input wire logic             group_six_request,
	input wire logic             group_seven_request,
	input wire logic             group_eight_request,
	input wire logic [AW-1:0]    reg_addr,
	input wire logic [DW-1:0]    reg_wdata,
	input wire logic             reg_wr,
	// Outputs
	input wire logic [GRP_N-1:0] active_onehot_q,
	input wire logic [EV_N-1:0]  ev_on_q,
	input wire logic [EV_N-1:0]  ev_off_q,
	input wire logic             ev_valid_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sgs_grp_t req;
	logic     ctl_wr;
	logic     frc_q;
	logic     used_wr_q;
	assign req = {group_eight_request, group_seven_request, group_six_request, group_five_request,
		group_four_request, group_three_request, group_two_request, group_one_request};
	assign ctl_wr = reg_wr && (reg_addr == REG_CTRL);
	// Forcing mode as last written; inputs only count while it is off
	always_ff @(posedge core_clk) begin
		if (rst) begin
			frc_q <= 1'b0;
		end else if (ctl_wr) begin
			frc_q <= reg_wdata[CTRL_FORCE_BIT];
		end
	end
	// A used-count cut drops the active group one cycle after its write
	always_ff @(posedge core_clk) begin
		if (rst) begin
			used_wr_q <= 1'b0;
		end else begin
			used_wr_q <= reg_wr && (reg_addr == REG_USED);
		end
	end
	AST_RST_GRP1: assert property ($fell(rst) |-> active_onehot_q == 8'h01)
		else $error("group one not active after reset");
	AST_ONEHOT: assert property ($onehot(active_onehot_q))
		else $error("active group not one-hot");
	AST_NO_LOWER: assert property ((!frc_q && !ctl_wr) ##1 $changed(active_onehot_q)
		|-> ($past(req) & (active_onehot_q - 8'h01)) == 8'h00)
		else $error("group taken while a higher input was high");
	AST_NEEDS_RISE: assert property ((!frc_q && !reg_wr && !used_wr_q) ##1 $changed(active_onehot_q)
		|-> ($past(req) & ~$past(req, 2) & active_onehot_q) != 8'h00)
		else $error("active group changed without its own request");
	AST_G1_KEEP: assert property (!frc_q && !ctl_wr && group_one_request && active_onehot_q[0]
		|=> active_onehot_q[0])
		else $error("held group one lost control");
	AST_FORCE_KEEP: assert property (frc_q && !reg_wr && !used_wr_q |=> $stable(active_onehot_q))
		else $error("inputs moved a forced group");
	AST_ACT_EV: assert property ($changed(active_onehot_q) |=>
		ev_on_q[EV_ACT_LSB +: GRP_N] == $past(active_onehot_q)
		&& ev_off_q[EV_ACT_LSB +: GRP_N] == $past(active_onehot_q, 2))
		else $error("active group events wrong");
	AST_REQ_EV: assert property (ev_on_q[EV_REQ_LSB +: GRP_N] == ($past(req) & ~$past(req, 2))
		&& ev_off_q[EV_REQ_LSB +: GRP_N] == (~$past(req) & $past(req, 2)))
		else $error("request events wrong");
	AST_EV_VALID: assert property (ev_valid_q == ((ev_on_q | ev_off_q) != '0))
		else $error("event valid out of step with events");
endmodule
bind sgs_selector sgs_selector_asserts sgs_selector_asserts_i (
	.core_clk(core_clk), .rst(rst), .group_one_request(group_one_request),
	.group_two_request(group_two_request), .group_three_request(group_three_request),
	.group_four_request(group_four_request), .group_five_request(group_five_request),
	.group_six_request(group_six_request), .group_seven_request(group_seven_request),
	.group_eight_request(group_eight_request), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .active_onehot_q(active_onehot_q), .ev_on_q(ev_on_q), .ev_off_q(ev_off_q),
	.ev_valid_q(ev_valid_q)
);
`default_nettype wire

// File: verif/tb_sgs_selector.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_count++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module tb_sgs_selector
	import sgs_pkg::*;
;
	logic            core_clk = 1'b0;
	logic            rst = 1'b1;
	sgs_grp_t        hold = '0;
	sgs_grp_t        pulse = '0;
	sgs_grp_t        req;
	sgs_grp_t        prv_q = '0;
	sgs_grp_t        exp_q = 8'h01;
	sgs_grp_t        hp [4] = '{8'h01, 8'h10, 8'h80, 8'h00};
	logic            trk = 1'b0;
	logic [AW-1:0]   reg_addr = '0;
	logic [DW-1:0]   reg_wdata = '0;
	logic            reg_wr = 1'b0;
	logic            reg_rd = 1'b0;
	logic [DW-1:0]   reg_rdata_q;
	sgs_grp_t        active_onehot_q;
	logic [EV_N-1:0] ev_on_q;
	logic [EV_N-1:0] ev_off_q;
	logic            ev_valid_q;
	logic [TSW-1:0]  ev_stamp_q;
	logic            irq_q;
	logic [31:0]     rnd = 32'h7483a5b4;
	logic [DW-1:0]   d;
	logic [TSW-1:0]  st;
	int              i;
	int              err_count = 0;
	int              samples_checked = 0;
	sgs_req_model sgs_req_model_i (.core_clk(core_clk), .rst(rst), .hold(hold), .pulse(pulse), .req_q(req));
	sgs_selector sgs_selector_i (
		.core_clk(core_clk), .rst(rst), .group_one_request(req[0]), .group_two_request(req[1]),
		.group_three_request(req[2]), .group_four_request(req[3]), .group_five_request(req[4]),
		.group_six_request(req[5]), .group_seven_request(req[6]), .group_eight_request(req[7]),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .active_onehot_q(active_onehot_q), .ev_on_q(ev_on_q),
		.ev_off_q(ev_off_q), .ev_valid_q(ev_valid_q), .ev_stamp_q(ev_stamp_q), .irq_q(irq_q)
	);
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Lowest rising group wins unless a higher input is already high
	function automatic sgs_grp_t exp_act(input sgs_grp_t act, input sgs_grp_t prv, input sgs_grp_t cur);
		sgs_grp_t r;
		r = cur & ~prv;
		r = r & (~r + 8'h01);
		exp_act = ((r != '0) && ((cur & (r - 8'h01)) == '0)) ? r : act;
	endfunction
	always @(posedge core_clk) begin
		prv_q <= req;
		exp_q <= rst ? 8'h01 : exp_act(exp_q, prv_q, req);
	end
	always @(negedge core_clk) begin
		if (trk) `CHK("active", exp_q, active_onehot_q)
	end
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata_q;
	endtask
	task automatic kick(input sgs_grp_t p);
		@(posedge core_clk);
		pulse <= p;
		@(posedge core_clk);
		pulse <= '0;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic wait_ev();
		int n;
		for (n = 0; n < 8; n++) begin
			@(posedge core_clk);
			#1;
			if (ev_valid_q === 1'b1) return;
		end
		err_count++;
		$display("BAD timeout waiting for event");
		test_done();
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		wait_ev();
		`CHK("announce", 1'b1, ev_on_q[EV_ACT_LSB])
		`CHK("rst_act", 8'h01, active_onehot_q)
		wr(REG_USED, 32'h8);
		@(posedge core_clk);
		#1 `CHK("used_on", 7'h7f, ev_on_q[EV_USED_LSB +: 7])
		$display("test reset done");
		trk = 1'b1;
		// Held group one, five, eight, then random holds, under random pulses
		foreach (hp[k]) begin
			hold <= hp[k];
			for (i = 0; i < 60; i++) begin
				@(posedge core_clk);
				rnd = lfsr(rnd);
				pulse <= rnd[7:0] & rnd[15:8] & rnd[23:16];
				if (k == 3 && rnd[31:29] == 3'h0) hold <= rnd[15:8] & rnd[26:19];
			end
		end
		@(posedge core_clk);
		hold <= '0;
		pulse <= '0;
		repeat (3) @(posedge core_clk);
		trk = 1'b0;
		$display("test random done");
		wr(REG_CTRL, 32'h31);
		#1 `CHK("force_grp", 8'h04, active_onehot_q)
		kick(8'h01);
		#1 `CHK("force_keep", 8'h04, active_onehot_q)
		wr(REG_LOCAL, 32'h6);
		#1 `CHK("local_grp", 8'h20, active_onehot_q)
		rd(REG_STATUS, d);
		`CHK("stat_force", 5'h16, d[4:0])
		wr(REG_CTRL, 32'h0);
		wr(REG_IRQ_MASK, 32'hf);
		wr(REG_IRQ_STAT, 32'hf);
		wr(REG_LOCAL, 32'h2);
		#1 `CHK("local_off", 8'h20, active_onehot_q)
		rd(REG_IRQ_STAT, d);
		`CHK("irq_stat", 4'h4, d[3:0])
		`CHK("irq_on", 1'b1, irq_q)
		wr(REG_IRQ_MASK, 32'h0);
		@(posedge core_clk);
		#1 `CHK("irq_mask", 1'b0, irq_q)
		wr(REG_IRQ_STAT, 32'h4);
		rd(REG_IRQ_STAT, d);
		`CHK("irq_w1c", 4'h0, d[3:0])
		$display("test force done");
		@(posedge core_clk);
		hold <= 8'h02;
		repeat (3) @(posedge core_clk);
		#1 `CHK("held_two", 8'h02, active_onehot_q)
		wr(REG_REMOTE, 32'h5);
		#1 `CHK("rem_block", 8'h02, active_onehot_q)
		rd(REG_STATUS, d);
		`CHK("fail_prio", 3'h4, d[26:24])
		@(posedge core_clk);
		hold <= '0;
		wr(REG_REMOTE, 32'h5);
		#1 `CHK("rem_take", 8'h10, active_onehot_q)
		wr(REG_USED, 32'h2);
		@(posedge core_clk);
		#1 `CHK("used_cut", 8'h01, active_onehot_q)
		`CHK("used_off", 7'h7e, ev_off_q[EV_USED_LSB +: 7])
		kick(8'h20);
		rd(REG_STATUS, d);
		`CHK("fail_ncfg", 3'h1, d[26:24])
		`CHK("ncfg_keep", 8'h01, active_onehot_q)
		$display("test remote done");
		@(posedge core_clk);
		pulse <= 8'h02;
		@(posedge core_clk);
		pulse <= '0;
		wait_ev();
		st = ev_stamp_q;
		rd(REG_TSTAMP, d);
		`CHK("stamp", 1'b1, (d - st) < 32'h2)
		rd(8'hfc, d);
		`CHK("unmapped", 32'h0, d)
		$display("test misc done");
		test_done();
	end
endmodule
`default_nettype wire
